// ==== ede_map.vh ====
// constants for the edge-differentiated execution block
// assumes inclusion by bare name from each file that uses it
`ifndef EDE_MAP_VH
`define EDE_MAP_VH
// variation codes
`define EDE_VAR_PLAIN    2'h0
`define EDE_VAR_RISE     2'h1
`define EDE_VAR_FALL     2'h2
// instruction kind codes
`define EDE_OP_LOAD      3'h0
`define EDE_OP_AND       3'h1
`define EDE_OP_OR        3'h2
`define EDE_OP_SET       3'h3
`define EDE_OP_RESET     3'h4
`define EDE_OP_OUTPUT    3'h5
`define EDE_OP_MOVE      3'h6
`define EDE_OP_OTHER     3'h7
// apb register byte addresses
`define EDE_ADDR_CTRL    12'h000
`define EDE_ADDR_STATUS  12'h004
`define EDE_ADDR_SCAN    12'h008
`define EDE_ADDR_FLAGS   12'h00C
// control fields
`define EDE_CTRL_START   0
`define EDE_CTRL_CYCEN   1
// status fields
`define EDE_ST_BUSY      0
`define EDE_ST_REJECT    1
// reset values
`define EDE_CTRL_RST     2'h2
`define EDE_ZERO32       32'h00000000
// refresh phases
`define EDE_PH_IDLE      3'h0
`define EDE_PH_PRE       3'h1
`define EDE_PH_EXEC      3'h2
`define EDE_PH_POST      3'h3
`define EDE_PH_CYCLIC    3'h4
`endif

// ==== ede_flag_mem.v ====
// previous-value flag store, one bit per edge instruction slot
// assumes one write port and one registered read port on clk
`timescale 1ns/1ns
module ede_flag_mem
#(
  parameter SLOTS = 64,
  parameter AW    = 6
)
(
  clk,
  reset_n,
  initPulse,
  initRise,
  rdAddr,
  rdData,
  wrEn,
  wrAddr,
  wrData,
  flagsLow
);
  input  wire          clk;
  input  wire          reset_n;
  input  wire          initPulse;
  input  wire [SLOTS-1:0] initRise;
  input  wire [AW-1:0] rdAddr;
  output reg           rdData;
  input  wire          wrEn;
  input  wire [AW-1:0] wrAddr;
  input  wire          wrData;
  output wire [31:0]   flagsLow;

  reg [SLOTS-1:0] flag_r;

  generate
    if (SLOTS >= 32)
    begin : g_wide
      assign flagsLow = flag_r[31:0];
    end
    else
    begin : g_narrow
      assign flagsLow = {{(32-SLOTS){1'b0}}, flag_r};
    end
  endgenerate

  // start of operation: rising slots load ON, falling slots OFF
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flag_r <= {SLOTS{1'b0}};
      rdData <= 1'b0;
    end
    else
    begin
      if (initPulse)
        flag_r <= initRise; // RULE9
      else if (wrEn)
        flag_r[wrAddr] <= wrData; // RULE20
      rdData <= flag_r[rdAddr];
    end
  end
endmodule

// ==== ede_refresh_seq.v ====
// sequences immediate and cyclic i/o refresh around instruction execution
// assumes the caller drops its request before done pulses
`timescale 1ns/1ns
`include "ede_map.vh"
module ede_refresh_seq
(
  clk,
  reset_n,
  immReq,
  cycReq,
  inStrobe,
  execStrobe,
  outStrobe,
  cycStrobe,
  done,
  busy
);
  input  wire clk;
  input  wire reset_n;
  input  wire immReq;
  input  wire cycReq;
  output reg  inStrobe;
  output reg  execStrobe;
  output reg  outStrobe;
  output reg  cycStrobe;
  output reg  done;
  output wire busy;

  reg [2:0] phase_r;

  assign busy = (phase_r != `EDE_PH_IDLE);

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase_r    <= `EDE_PH_IDLE;
      inStrobe   <= 1'b0;
      execStrobe <= 1'b0;
      outStrobe  <= 1'b0;
      cycStrobe  <= 1'b0;
      done       <= 1'b0;
    end
    else
    begin
      inStrobe   <= 1'b0;
      execStrobe <= 1'b0;
      outStrobe  <= 1'b0;
      cycStrobe  <= 1'b0;
      done       <= 1'b0;
      case (phase_r)
        `EDE_PH_IDLE:
        begin
          if (cycReq)
          begin
            phase_r <= `EDE_PH_CYCLIC;
            cycStrobe <= 1'b1; // RULE19
          end
          else if (immReq)
          begin
            phase_r <= `EDE_PH_PRE;
            inStrobe <= 1'b1; // RULE18
          end
        end
        `EDE_PH_PRE:
        begin
          phase_r <= `EDE_PH_EXEC;
          execStrobe <= 1'b1;
        end
        `EDE_PH_EXEC:
        begin
          phase_r <= `EDE_PH_POST;
          outStrobe <= 1'b1; // RULE18
        end
        `EDE_PH_POST:
        begin
          phase_r <= `EDE_PH_IDLE;
          done <= 1'b1;
        end
        `EDE_PH_CYCLIC:
        begin
          phase_r <= `EDE_PH_IDLE;
          done <= 1'b1;
        end
        default:
          phase_r <= `EDE_PH_IDLE;
      endcase
    end
  end
endmodule

// ==== ede_exec_ctrl.v ====
// execution-condition logic for one instruction step per request
// What the document requires
// RULE1 - plain output instruction runs every scan while its condition holds
// RULE2 - rising output instruction runs only in the OFF-to-ON scan
// RULE3 - falling output instruction runs only in the ON-to-OFF scan
// RULE4 - rising input instruction gives ON for one scan on OFF-to-ON
// RULE5 - inverted rising input gives OFF for one scan on OFF-to-ON
// RULE6 - falling input instruction gives ON for one scan on ON-to-OFF
// RULE7 - inverted falling input gives OFF for one scan on ON-to-OFF
// RULE8 - falling variant only on load, and, or, set, reset instructions
// RULE9 - at start rising flags go ON, falling flags go OFF; here slots from 32 up always start OFF
// RULE10 - rising output ON only when condition ON and flag OFF
// RULE11 - flags inside an active interlock are not updated
// RULE12 - flags of jumped instructions stay unchanged
// RULE13 - edge output only when input differs from stored flag
// RULE14 - immediate variant refreshes operand i/o at execution time; here only output steps that execute refresh, input steps get none
// RULE15 - programs must not feed always-ON or first-cycle flag to rising
// RULE16 - programs must not feed always-OFF flag to falling
// RULE17 - both cyclic and immediate refresh are supported
// RULE18 - inputs refresh just before execution, outputs just after
// RULE19 - cyclic refresh updates all i/o after all tasks finish
// RULE20 - each evaluation copies the condition into the flag
// assumes a sequencer presents one step at a time on stepValid and
// waits for stepDone; apb master follows the usual two-phase protocol
`timescale 1ns/1ns
`include "ede_map.vh"
module ede_exec_ctrl
#(
  parameter SLOTS = 64,
  parameter AW    = 6
)
(
  clk,
  reset_n,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  stepValid,
  stepSlot,
  stepVar,
  stepOp,
  stepInvert,
  stepIsInput,
  stepImm,
  stepCond,
  interlockOff,
  jumpSkip,
  scanEnd,
  stepDone,
  execFire,
  condOut,
  stepReject,
  ioInRefresh,
  ioOutRefresh,
  ioCycRefresh
);
  input  wire          clk;
  input  wire          reset_n;
  input  wire          psel;
  input  wire          penable;
  input  wire          pwrite;
  input  wire [11:0]   paddr;
  input  wire [31:0]   pwdata;
  output reg  [31:0]   prdata;
  output reg           pready;
  output reg           pslverr;
  input  wire          stepValid;
  input  wire [AW-1:0] stepSlot;
  input  wire [1:0]    stepVar;
  input  wire [2:0]    stepOp;
  input  wire          stepInvert;
  input  wire          stepIsInput;
  input  wire          stepImm;
  input  wire          stepCond;
  input  wire          interlockOff;
  input  wire          jumpSkip;
  input  wire          scanEnd;
  output reg           stepDone;
  output reg           execFire;
  output reg           condOut;
  output reg           stepReject;
  output reg           ioInRefresh;
  output reg           ioOutRefresh;
  output reg           ioCycRefresh;

  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_EVAL = 2'h2;
  localparam ST_REFR = 2'h3;

  reg  [1:0]       state_r;
  reg  [1:0]       ctrl_r;
  reg  [SLOTS-1:0] riseMap_r;
  reg  [31:0]      scanCount_r;
  reg              initPulse_r;
  reg              rejectSticky_r;
  reg              cycPending_r;
  wire             prevFlag;
  wire [31:0]      flagsLow;
  wire             seqIn;
  wire             seqExec;
  wire             seqOut;
  wire             seqCyc;
  wire             seqDone;
  wire             seqBusy;
  reg              memWe;
  reg              immReq;

  // falling variant is only legal on load, and, or, set and reset
  function fallLegal;
    input [2:0] op;
    begin
      fallLegal = (op == `EDE_OP_LOAD) || (op == `EDE_OP_AND) || (op == `EDE_OP_OR)
                  || (op == `EDE_OP_SET) || (op == `EDE_OP_RESET); // RULE8
    end
  endfunction

  // edge seen when present state differs from the stored flag in the variation's direction; plain passes the state through
  function edgeSeen;
    input [1:0] vsel;
    input       cur;
    input       prev;
    begin
      case (vsel)
        `EDE_VAR_RISE: edgeSeen = cur & ~prev; // RULE10 RULE13
        `EDE_VAR_FALL: edgeSeen = ~cur & prev; // RULE13
        default:       edgeSeen = cur;
      endcase
    end
  endfunction

  // bus word to rise map: slots from 32 up cannot be set over the bus and start OFF
  function [SLOTS-1:0] riseFromWord;
    input [31:0] w;
    integer      i;
    begin
      riseFromWord = {SLOTS{1'b0}};
      for (i = 0; i < 32; i = i + 1)
        if (i < SLOTS)
          riseFromWord[i] = w[i];
    end
  endfunction

  // flag is written at the evaluate edge with the condition that the step saw
  ede_flag_mem #(.SLOTS(SLOTS), .AW(AW)) u_flags
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .initPulse(initPulse_r),
    .initRise (riseMap_r),
    .rdAddr   (stepSlot),
    .rdData   (prevFlag),
    .wrEn     (memWe),
    .wrAddr   (stepSlot),
    .wrData   (stepCond),
    .flagsLow (flagsLow)
  );

  // cyclic refresh waits until the step sequencer is idle
  ede_refresh_seq u_refresh
  (
    .clk       (clk),
    .reset_n   (reset_n),
    .immReq    (immReq),
    .cycReq    (cycPending_r && state_r == ST_IDLE),
    .inStrobe  (seqIn),
    .execStrobe(seqExec),
    .outStrobe (seqOut),
    .cycStrobe (seqCyc),
    .done      (seqDone),
    .busy      (seqBusy)
  );

  // a refused step finishes with no output and no flag update
  wire illegal = (stepVar == `EDE_VAR_FALL) && !fallLegal(stepOp);
  wire isEdge  = (stepVar == `EDE_VAR_RISE) || (stepVar == `EDE_VAR_FALL);
  // a step that is interlocked or jumped is not evaluated and keeps its flag
  wire evaluated = !interlockOff && !jumpSkip; // RULE11 RULE12

  // only an output step that really executes asks for an immediate refresh;
  // input steps ignore the refresh variant
  always @*
  begin
    memWe  = (state_r == ST_EVAL) && isEdge && evaluated && !illegal; // RULE20
    immReq = (state_r == ST_EVAL) && stepImm && !stepIsInput && evaluated && !illegal
             && edgeSeen(stepVar, stepCond, prevFlag); // RULE14
  end

  // apb slave, zero wait states
  wire apbAccess = psel && penable;
  wire [31:0] statusWord = {30'h0, rejectSticky_r, seqBusy};

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata         <= `EDE_ZERO32;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      ctrl_r         <= `EDE_CTRL_RST;
      riseMap_r      <= {SLOTS{1'b0}};
      initPulse_r    <= 1'b0;
      rejectSticky_r <= 1'b0;
    end
    else
    begin
      pready      <= psel && !penable;
      pslverr     <= 1'b0;
      initPulse_r <= 1'b0;
      if (stepReject)
        rejectSticky_r <= 1'b1;
      if (psel && !penable)
      begin
        case (paddr)
          `EDE_ADDR_CTRL:   prdata <= {30'h0, ctrl_r};
          `EDE_ADDR_STATUS: prdata <= statusWord;
          `EDE_ADDR_SCAN:   prdata <= scanCount_r;
          `EDE_ADDR_FLAGS:  prdata <= flagsLow;
          default:
          begin
            prdata  <= `EDE_ZERO32;
            pslverr <= 1'b1;
          end
        endcase
      end
      // a write lands at the access edge only, so an abandoned setup changes nothing
      if (apbAccess && pready && pwrite)
      begin
        case (paddr)
          `EDE_ADDR_CTRL:
          begin
            ctrl_r <= pwdata[1:0];
            initPulse_r <= pwdata[`EDE_CTRL_START]; // RULE9
          end
          `EDE_ADDR_STATUS:
            if (pwdata[`EDE_ST_REJECT] && !stepReject)
              rejectSticky_r <= 1'b0;
          `EDE_ADDR_FLAGS:
            riseMap_r <= riseFromWord(pwdata);
          default:
            ;
        endcase
      end
    end
  end

  // step sequencer
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r      <= ST_IDLE;
      stepDone     <= 1'b0;
      execFire     <= 1'b0;
      condOut      <= 1'b0;
      stepReject   <= 1'b0;
      cycPending_r <= 1'b0;
      scanCount_r  <= `EDE_ZERO32;
      ioInRefresh  <= 1'b0;
      ioOutRefresh <= 1'b0;
      ioCycRefresh <= 1'b0;
    end
    else
    begin
      stepDone     <= 1'b0;
      execFire     <= 1'b0;
      stepReject   <= 1'b0;
      ioInRefresh  <= seqIn;
      ioOutRefresh <= seqOut;
      ioCycRefresh <= seqCyc;
      // all tasks of the scan done: one cyclic refresh before the next
      if (scanEnd && ctrl_r[`EDE_CTRL_CYCEN])
        cycPending_r <= 1'b1; // RULE17 RULE19
      else if (seqCyc)
        cycPending_r <= 1'b0;
      if (seqCyc)
        scanCount_r <= scanCount_r + 32'h00000001;
      case (state_r)
        ST_IDLE:
          // the master still holds stepValid at the edge where it sees stepDone;
          // taking it there would run the finished step a second time
          if (stepValid && !stepDone && !seqBusy && !cycPending_r)
            state_r <= ST_READ;
        ST_READ:
          state_r <= ST_EVAL;
        ST_EVAL:
        begin
          if (illegal)
          begin
            stepReject <= 1'b1; // RULE8
            stepDone   <= 1'b1;
            condOut    <= 1'b0;
            state_r    <= ST_IDLE;
          end
          else if (!evaluated)
          begin
            condOut  <= 1'b0;
            stepDone <= 1'b1;
            state_r  <= ST_IDLE;
          end
          else if (stepIsInput)
          begin
            // one-scan pulse, inverted forms give a one-scan gap
            condOut  <= edgeSeen(stepVar, stepCond, prevFlag) ^ stepInvert; // RULE4 RULE5 RULE6 RULE7
            stepDone <= 1'b1;
            state_r  <= ST_IDLE;
          end
          else if (immReq)
          begin
            state_r <= ST_REFR; // RULE14
          end
          else
          begin
            execFire <= edgeSeen(stepVar, stepCond, prevFlag); // RULE1 RULE2 RULE3
            condOut  <= stepCond;
            stepDone <= 1'b1;
            state_r  <= ST_IDLE;
          end
        end
        ST_REFR:
        begin
          if (seqExec)
            execFire <= 1'b1; // RULE18
          if (seqDone)
          begin
            condOut  <= stepCond;
            stepDone <= 1'b1;
            state_r  <= ST_IDLE;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== ede_io_units.sv ====
// model of the external i/o units refreshed by the block
// assumes refresh strobes are one-cycle pulses on clk
`timescale 1ns/1ns
module ede_io_units
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        ioInRefresh,
  input wire logic        ioOutRefresh,
  input wire logic        ioCycRefresh,
  output logic            orderErr,
  output logic [7:0]      cycCount
);
  logic       inFlight_r;
  logic       orderErr_r;
  logic [7:0] cycCount_r;
  assign orderErr = orderErr_r;
  assign cycCount = cycCount_r;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      inFlight_r <= 1'b0;
      orderErr_r <= 1'b0;
      cycCount_r <= 8'h00;
    end
    else
    begin
      // inputs must be fetched before the matching output write-back
      if (ioInRefresh)
        inFlight_r <= 1'b1;
      if (ioOutRefresh)
        inFlight_r <= 1'b0;
      if ((ioOutRefresh && !inFlight_r) || (ioCycRefresh && inFlight_r))
        orderErr_r <= 1'b1;
      if (ioCycRefresh)
        cycCount_r <= cycCount_r + 8'h01;
    end
  end
endmodule

// ==== ede_exec_ctrl_properties.sv ====
// concurrent checks on the execution-condition block ports
// assumes cyclic enable stays set while scanEnd is pulsed
`timescale 1ns/1ns
`include "ede_map.vh"
module ede_exec_props
#(
  parameter SLOTS = 64,
  parameter AW    = 6
)
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [1:0] stepVar,
  input wire logic [2:0] stepOp,
  input wire logic       stepInvert,
  input wire logic       stepIsInput,
  input wire logic       stepImm,
  input wire logic       stepCond,
  input wire logic       interlockOff,
  input wire logic       jumpSkip,
  input wire logic       scanEnd,
  input wire logic       stepDone,
  input wire logic       execFire,
  input wire logic       condOut,
  input wire logic       stepReject,
  input wire logic       ioInRefresh,
  input wire logic       ioOutRefresh,
  input wire logic       ioCycRefresh
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_live;
    stepDone && !jumpSkip && !interlockOff;
  endsequence
  sequence s_post;
    ioOutRefresh ##1 stepDone;
  endsequence
  a_plain_fires: assert property (s_live ##0 (stepVar == `EDE_VAR_PLAIN && !stepIsInput
    && stepOp == `EDE_OP_OUTPUT && !stepImm && stepCond) |-> execFire)
    else $error("plain output step did not execute");
  a_rise_needs_on: assert property ((execFire && stepVar == `EDE_VAR_RISE) |-> stepCond)
    else $error("rising execution with condition off");
  a_fall_needs_off: assert property ((execFire && stepVar == `EDE_VAR_FALL) |-> !stepCond)
    else $error("falling execution with condition on");
  a_edge_in_cond: assert property ((stepDone && stepIsInput && !stepInvert && condOut
    && stepVar != `EDE_VAR_PLAIN) |-> (stepCond == (stepVar == `EDE_VAR_RISE)))
    else $error("edge input pulse against the present state");
  a_reject_bad_op: assert property (stepReject |->
    (stepVar == `EDE_VAR_FALL && stepOp > `EDE_OP_RESET))
    else $error("reject on a legal step");
  a_skip_quiet: assert property ((stepDone && (jumpSkip || interlockOff))
    |-> (!execFire && !condOut))
    else $error("skipped step produced output");
  a_imm_walk: assert property (ioInRefresh |-> ##2 s_post)
    else $error("immediate refresh walk out of order");
  a_cyc_follows: assert property ($rose(scanEnd) |-> ##[1:6] ioCycRefresh)
    else $error("no cyclic refresh after scan end");
endmodule
bind ede_exec_ctrl ede_exec_props #(.SLOTS(SLOTS), .AW(AW)) u_props (.clk(clk),
  .reset_n(reset_n), .stepVar(stepVar), .stepOp(stepOp), .stepInvert(stepInvert),
  .stepIsInput(stepIsInput), .stepImm(stepImm), .stepCond(stepCond),
  .interlockOff(interlockOff), .jumpSkip(jumpSkip), .scanEnd(scanEnd), .stepDone(stepDone),
  .execFire(execFire), .condOut(condOut), .stepReject(stepReject),
  .ioInRefresh(ioInRefresh), .ioOutRefresh(ioOutRefresh), .ioCycRefresh(ioCycRefresh));

// ==== tb_edge_differentiated_execution.sv ====
// self-checking bench for the execution-condition block
// assumes the design header and the i/o unit model are compiled first
`timescale 1ns/1ns
`include "ede_map.vh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module tb_edge_differentiated_execution;
  logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        stepValid = 1'b0, stepInvert = 1'b0, stepIsInput = 1'b0, stepImm = 1'b0;
  logic        stepCond = 1'b0, interlockOff = 1'b0, jumpSkip = 1'b0, scanEnd = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [5:0]  stepSlot = 6'h00;
  logic [1:0]  stepVar = 2'h0;
  logic [2:0]  stepOp = 3'h0;
  logic [7:0]  cycCount;
  logic        pready, pslverr, stepDone, execFire, condOut, stepReject, orderErr;
  logic        ioInRefresh, ioOutRefresh, ioCycRefresh, gotFire, gotCond, gotRej, errSeen;
  int          fail_count = 0, samples_checked = 0, nIn, nOut;
  // edge rows toggle their condition: none rides a constant ON or OFF input
  // row nibbles: slot, variation, op, {invert, input, cond, expected}
  logic [15:0] rows [23] = '{16'h0053, 16'h0053, 16'h0050, 16'h1152, 16'h1150, 16'h1153,
    16'h1152, 16'h2230, 16'h2232, 16'h2231, 16'h2230, 16'h3104, 16'h3107, 16'h3106,
    16'h410D, 16'h410E, 16'h410F, 16'h5216, 16'h5215, 16'h5214, 16'h622F, 16'h622C, 16'h622D};
  always #50 clk = ~clk;
  ede_exec_ctrl dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stepValid(stepValid), .stepSlot(stepSlot), .stepVar(stepVar),
    .stepOp(stepOp), .stepInvert(stepInvert), .stepIsInput(stepIsInput), .stepImm(stepImm),
    .stepCond(stepCond), .interlockOff(interlockOff), .jumpSkip(jumpSkip), .scanEnd(scanEnd),
    .stepDone(stepDone), .execFire(execFire), .condOut(condOut), .stepReject(stepReject),
    .ioInRefresh(ioInRefresh), .ioOutRefresh(ioOutRefresh), .ioCycRefresh(ioCycRefresh));
  ede_io_units units (.clk(clk), .reset_n(reset_n), .ioInRefresh(ioInRefresh),
    .ioOutRefresh(ioOutRefresh), .ioCycRefresh(ioCycRefresh), .orderErr(orderErr),
    .cycCount(cycCount));
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 40);
    if (pready !== 1'b1)
      fail_count++;
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic step(input logic [15:0] r, input logic lock, input logic skip,
                      input logic imm);
    int n;
    n = 0;
    gotFire = 1'b0;
    gotRej = 1'b0;
    nIn = 0;
    nOut = 0;
    @(posedge clk);
    stepValid <= 1'b1;
    stepSlot <= {2'h0, r[15:12]};
    stepVar <= r[9:8];
    stepOp <= r[6:4];
    stepInvert <= r[3];
    stepIsInput <= r[2];
    stepCond <= r[1];
    interlockOff <= lock;
    jumpSkip <= skip;
    stepImm <= imm;
    do
    begin
      @(posedge clk);
      gotFire |= execFire;
      gotRej |= stepReject;
      nIn += ioInRefresh;
      nOut += ioOutRefresh;
    end
    while (stepDone !== 1'b1 && ++n < 40);
    if (stepDone !== 1'b1)
      fail_count++;
    gotCond = condOut;
    stepValid <= 1'b0;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, `EDE_ADDR_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h00000002, rd)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped error", 1'b1, errSeen)
    apb(1'b1, `EDE_ADDR_FLAGS, 32'h0000001A);
    apb(1'b1, `EDE_ADDR_CTRL, 32'h00000003);
    apb(1'b0, `EDE_ADDR_FLAGS, 32'h0);
    `CHK("start flags", 32'h0000001A, rd)
    foreach (rows[i])
    begin
      step(rows[i], 1'b0, 1'b0, 1'b0);
      if (rows[i][2])
        `CHK("input cond", rows[i][0], gotCond)
      else
        `CHK("output fire", rows[i][0], gotFire)
      `CHK("legal reject", 1'b0, gotRej)
    end
    // slot 1 flag is ON, slot 2 flag is OFF: a flag update by the blocked step would show as a fire
    step(16'h1150, 1'b1, 1'b0, 1'b0);
    step(16'h1152, 1'b0, 1'b0, 1'b0);
    `CHK("interlock fire", 1'b0, gotFire)
    step(16'h2232, 1'b0, 1'b1, 1'b0);
    step(16'h2230, 1'b0, 1'b0, 1'b0);
    `CHK("jump fire", 1'b0, gotFire)
    apb(1'b0, `EDE_ADDR_FLAGS, 32'h0);
    `CHK("kept flags", 32'h0000001A, rd & 32'h0000007E)
    for (int k = 5; k < 8; k++)
    begin
      step({8'h72, 1'b0, 3'(k), 4'h2}, 1'b0, 1'b0, 1'b0);
      `CHK("illegal reject", 1'b1, gotRej)
    end
    apb(1'b0, `EDE_ADDR_STATUS, 32'h0);
    `CHK("reject sticky", 1'b1, rd[1])
    step(16'h0063, 1'b0, 1'b0, 1'b1);
    `CHK("imm fire", 1'b1, gotFire)
    `CHK("imm refresh", 2, nIn + nOut)
    @(posedge clk);
    scanEnd <= 1'b1;
    @(posedge clk);
    scanEnd <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("cyclic count", 8'h01, cycCount)
    apb(1'b1, `EDE_ADDR_SCAN, 32'h00000005);
    apb(1'b0, `EDE_ADDR_SCAN, 32'h0);
    `CHK("scan count", 32'h00000001, rd)
    `CHK("refresh order", 1'b0, orderErr)
    wrap_up;
  end
endmodule
